/* verilog/vcap_pkg.sv */
// Constants shared by the video output control bank and its sync filter.
// Assumes a 100 MHz system clock and byte-wide registers on 32-bit words.
package vcap_pkg;
  // Clock period and the step of the sync filter window, in ns.
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned WIN_STEP_NS = 25;
  // Pixel clock period and the quarter-period delay derived from it.
  localparam int unsigned LINK_NS = 80;
  localparam int unsigned QUARTER_CYC = (LINK_NS / 4 / CLK_NS < 1) ? 1 : LINK_NS / 4 / CLK_NS;
  // Sync activity timeout in us and its cycle count.
  localparam int unsigned ACT_TIMEOUT_US = 100;
  localparam int unsigned ACT_TIMEOUT_DEF = ACT_TIMEOUT_US * 1000 / CLK_NS;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_INPWR = 6'h1e;
  localparam logic [5:0] IDX_OSEL1 = 6'h1f;
  localparam logic [5:0] IDX_OSEL2 = 6'h20;
  localparam logic [5:0] IDX_FIXA = 6'h21;
  localparam logic [5:0] IDX_FIXB = 6'h22;
  localparam logic [5:0] IDX_WIN = 6'h23;
  localparam logic [5:0] IDX_SDET = 6'h24;
  // Values after reset.
  localparam logic [7:0] RST_INPWR = 8'h30;
  localparam logic [7:0] RST_OSEL1 = 8'h94;
  localparam logic [7:0] RST_OSEL2 = 8'h04;
  localparam logic [7:0] RST_FIXA = 8'h20;
  localparam logic [7:0] RST_FIXB = 8'h32;
  localparam logic [7:0] RST_WIN = 8'h0a;
  // Field positions in the input and power control register.
  localparam int unsigned PD_AUTO_B = 4;
  localparam int unsigned PD_REG_B = 3;
  localparam int unsigned PD_POL_B = 2;
  localparam int unsigned PD_FAST_B = 1;
  localparam int unsigned SOG_PD_HIZ_B = 0;
  // Field positions in the first output select register.
  localparam int unsigned MODE_HI = 7;
  localparam int unsigned MODE_LO = 5;
  localparam int unsigned PRI_EN_B = 4;
  localparam int unsigned SEC_EN_B = 3;
  localparam int unsigned DRV_HI_B = 2;
  localparam int unsigned DRV_LO_B = 1;
  localparam int unsigned CLK_INV_B = 0;
  // Field positions in the second output select register.
  localparam int unsigned CKSEL_HI = 7;
  localparam int unsigned CKSEL_LO = 6;
  localparam int unsigned ALL_HIZ_B = 5;
  localparam int unsigned SOG_HIZ_B = 4;
  localparam int unsigned FIELD_POL_B = 3;
  localparam int unsigned PLL_FILT_B = 2;
  localparam int unsigned SPROC_SEL_B = 1;
  // Activity bit in the sync detect register.
  localparam int unsigned ACT_B = 7;
  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Output format modes.
  typedef enum logic [2:0] {MODE_RGB444 = 3'b100, MODE_YCC422 = 3'b101,
                            MODE_DDR444 = 3'b110} out_mode_t;
  // Data clock sources.
  typedef enum logic [1:0] {CK_PIX = 2'b00, CK_PIX90 = 2'b01, CK_PIX2X = 2'b10,
                            CK_HALF = 2'b11} clk_sel_t;
  // Output drive strengths.
  typedef enum logic [1:0] {DRV_LOW = 2'b00, DRV_MED = 2'b01, DRV_HIGH = 2'b10} drive_t;
endpackage : vcap_pkg

/* verilog/sync_filter_if.sv */
// Link between the output control bank and its sync window filter.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface sync_filter_if;
  logic raw;          // Raw selected sync level.
  logic [7:0] window; // Window width in 25 ns steps.
  logic filtered;     // One-cycle pulse for each passed leading edge.
  logic regen;        // One-cycle regenerated sync pulse.
  logic locked;       // Filter has seen an edge inside its window.
  modport ctrl(output raw, output window, input filtered, input regen, input locked);
  modport filt(input raw, input window, output filtered, output regen, output locked);
endinterface : sync_filter_if

/* verilog/sync_window_filter.sv */
// Sync window filter: passes leading edges near the predicted one.
// Assumes the raw sync is already synchronised to the system clock.
`timescale 1ns/10ps
module sync_window_filter
  import vcap_pkg::*;
#(
  parameter int unsigned PER_W = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Link to the control bank.
  sync_filter_if.filt sf
);
  // The window and a line period must fit the counter.
  if (PER_W < 12) begin : g_chk
    $error("sync_window_filter: PER_W too small");
  end

  // All filter state.
  typedef struct packed {
    logic raw_d;             // Last raw level, for edge detection.
    logic [PER_W-1:0] cnt;   // Cycles since the last passed edge.
    logic [PER_W-1:0] per;   // Learned line period.
    logic locked;            // Last edge fell inside the window.
    logic filt;              // Passed edge pulse.
    logic regen;             // Regenerated pulse.
  } fst_t;

  fst_t fst_ff;
  fst_t nxt_fst;
  logic [PER_W:0] wc;        // Window half-width in cycles.
  logic near;                // Edge is inside the window.

  // Compute the next filter state.
  always_comb begin
    nxt_fst = fst_ff;
    nxt_fst.raw_d = sf.raw;
    nxt_fst.filt = 1'b0;
    nxt_fst.regen = 1'b0;
    wc = (PER_W+1)'((32'(sf.window) * WIN_STEP_NS) / CLK_NS);
    near = ({1'b0, fst_ff.cnt} + wc >= {1'b0, fst_ff.per}) &&
           ({1'b0, fst_ff.cnt} <= {1'b0, fst_ff.per} + wc);
    // Count up, saturating; a lost line drops the lock.
    if (!(&fst_ff.cnt)) begin
      nxt_fst.cnt = fst_ff.cnt + 1'b1;
    end else begin
      nxt_fst.locked = 1'b0;
    end
    // Regenerate the sync where the next edge is expected.
    if (fst_ff.per != '0 && fst_ff.cnt == fst_ff.per) begin
      nxt_fst.regen = 1'b1;
    end
    // A leading edge passes when unlocked or inside the window.
    if (sf.raw && !fst_ff.raw_d) begin
      if (!fst_ff.locked || near) begin
        nxt_fst.filt = 1'b1;
        nxt_fst.per = fst_ff.cnt;
        nxt_fst.cnt = '0;
        nxt_fst.locked = near && fst_ff.per != '0;
      end
    end
  end

  // Register the filter state.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fst_ff <= '0;
    end else begin
      fst_ff <= nxt_fst;
    end
  end

  assign sf.filtered = fst_ff.filt;
  assign sf.regen = fst_ff.regen;
  assign sf.locked = fst_ff.locked;
endmodule : sync_window_filter

/* verilog/video_capture_output_control.sv */
// Output control register bank of a video capture interface.
// Assumes an AXI4-Lite master on the system clock and pins from outside it.
//
// How it works
// - Polarity bit sets power-down pin active level.
// - Fast switching keeps power, only floats outputs.
// - Bit zero floats green sync during power-down.
// - Mode field picks RGB, YCbCr or DDR.
// - Primary enable bit drives or floats primary.
// - Secondary enable bit drives or floats secondary.
// - Drive field: low, medium, high except vsync.
// - Invert bit inverts the data clock output.
// - Clock select: pixel, shifted, double, half.
// - Global float bit floats all but green sync.
// - Green sync float bit floats that pin.
// - Field polarity bit swaps odd/even encoding.
// - PLL reference takes filtered or raw sync.
// - Sync processor takes regenerated or raw sync.
// - Window width in 25 ns steps gates pulses.
// - Status bit seven shows horizontal sync activity.
// - Control select picks manual or automatic power-down.
`timescale 1ns/10ps
module video_capture_output_control
  import vcap_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned ACT_TIMEOUT_CYC = ACT_TIMEOUT_DEF,
  parameter int unsigned PER_W = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // AXI4-Lite write channels.
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read channels.
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Pins from outside the clock domain.
  input wire logic power_down_pin_i,
  input wire logic horizontal_sync_input_zero_i,
  input wire logic selected_horizontal_sync_input_i,
  input wire logic selected_green_sync_input_i,
  input wire logic pixel_clock_i,
  // Inputs from capture logic on the same clock.
  input wire logic use_green_sync_i,
  input wire logic field_is_odd_i,
  // Output enables and format controls.
  output logic primary_oe_o,
  output logic secondary_oe_o,
  output logic vertical_sync_out_pin_oe_o,
  output logic green_sync_out_pin_o,
  output logic green_sync_out_pin_oe_o,
  output logic data_clock_out_pin_o,
  output logic data_clock_out_pin_oe_o,
  output logic [1:0] drive_strength_o,
  output logic [2:0] output_mode_o,
  output logic field_out_o,
  // Sync routing and power.
  output logic pll_ref_sync_o,
  output logic sync_proc_sync_o,
  output logic core_powered_o
);
  // The address must reach the last register and the timeout must count.
  if (ADDR_W < 8 || ACT_TIMEOUT_CYC < 2) begin : g_chk
    $error("video_capture_output_control: bad parameter");
  end

  localparam int unsigned ACT_W = $clog2(ACT_TIMEOUT_CYC + 1);
  localparam logic [ACT_W-1:0] ACT_LAST = ACT_W'(ACT_TIMEOUT_CYC - 1);

  // All state of the bank.
  typedef struct packed {
    logic [2:0] pd_s, hs0_s, hs_s, sog_s, pck_s; // Three-stage synchronisers.
    logic pd_v, hs0_v, hs_v, sog_v, pck_v;       // Agreed pin levels.
    logic [7:0] inpwr, osel1, osel2, fixa, fixb, win; // Writable registers.
    out_mode_t mode;                  // Format in force.
    logic act;                        // Sync activity seen lately.
    logic [ACT_W-1:0] act_cnt;        // Cycles since the last sync edge.
    logic [QUARTER_CYC-1:0] pck_dly;  // Pixel clock delay line.
    logic pck_half;                   // Half-rate pixel clock.
    logic aw_got, w_got;              // Write address and data held.
    logic [ADDR_W-1:0] awaddr;        // Held write address.
    logic [7:0] wdata;                // Held write data, low lane.
    logic wstrb0;                     // Held low lane strobe.
    logic bvalid, rvalid;             // Answers pending.
    logic [1:0] bresp, rresp;         // Answer codes.
    logic [7:0] rdata;                // Read data.
    logic pri_oe, sec_oe, vs_oe, sog_oe, dck_oe, dck, field; // Output pins.
    logic pll_ref, sproc, powered;    // Sync routing and power.
    drive_t drive;                    // Drive strength.
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  sync_filter_if sf ();

  // Sync window filter on the raw selected sync.
  sync_window_filter #(.PER_W(PER_W)) u_filt (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .sf(sf)
  );

  assign sf.raw = use_green_sync_i ? st_ff.sog_v : st_ff.hs_v;
  assign sf.window = st_ff.win;

  // A level counts once the second and third stages agree.
  function automatic logic agree(input logic [2:0] s, input logic v);
    return (s[1] == s[2]) ? s[2] : v;
  endfunction : agree

  logic aw_now, w_now, pd_req, pin_req, pix90, ck;
  logic [5:0] widx, ridx;
  logic [7:0] rd;

  // Next state: pins, bus, registers and outputs.
  always_comb begin
    nxt_st = st_ff;
    // Shift the pins through the synchronisers.
    nxt_st.pd_s = {st_ff.pd_s[1:0], power_down_pin_i};
    nxt_st.hs0_s = {st_ff.hs0_s[1:0], horizontal_sync_input_zero_i};
    nxt_st.hs_s = {st_ff.hs_s[1:0], selected_horizontal_sync_input_i};
    nxt_st.sog_s = {st_ff.sog_s[1:0], selected_green_sync_input_i};
    nxt_st.pck_s = {st_ff.pck_s[1:0], pixel_clock_i};
    nxt_st.pd_v = agree(st_ff.pd_s, st_ff.pd_v);
    nxt_st.hs0_v = agree(st_ff.hs0_s, st_ff.hs0_v);
    nxt_st.hs_v = agree(st_ff.hs_s, st_ff.hs_v);
    nxt_st.sog_v = agree(st_ff.sog_s, st_ff.sog_v);
    nxt_st.pck_v = agree(st_ff.pck_s, st_ff.pck_v);

    // An edge on sync input zero restarts the activity timer.
    if (nxt_st.hs0_v != st_ff.hs0_v) begin
      nxt_st.act = 1'b1;
      nxt_st.act_cnt = '0;
    end else if (st_ff.act_cnt == ACT_LAST) begin
      nxt_st.act = 1'b0;
    end else begin
      nxt_st.act_cnt = st_ff.act_cnt + 1'b1;
    end

    // Hold write address and data until both have come.
    aw_now = st_ff.aw_got || (s_axi_awvalid_i && s_axi_awready_o);
    w_now = st_ff.w_got || (s_axi_wvalid_i && s_axi_wready_o);
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata_i[7:0];
      nxt_st.wstrb0 = s_axi_wstrb_i[0];
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    widx = nxt_st.awaddr[7:2];
    // Perform the write once both halves are present.
    if (aw_now && w_now && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      if ((nxt_st.awaddr >> 8) != '0) begin
        nxt_st.bresp = RESP_SLVERR;
      end else if (nxt_st.wstrb0) begin
        unique case (widx)
          IDX_INPWR: nxt_st.inpwr = nxt_st.wdata;
          IDX_OSEL1: begin
            nxt_st.osel1 = nxt_st.wdata;
            // Only a defined code changes the format.
            if (nxt_st.wdata[MODE_HI:MODE_LO] inside {MODE_RGB444, MODE_YCC422,
                MODE_DDR444}) begin
              nxt_st.mode = out_mode_t'(nxt_st.wdata[MODE_HI:MODE_LO]);
            end
          end
          IDX_OSEL2: nxt_st.osel2 = nxt_st.wdata;
          IDX_FIXA: nxt_st.fixa = nxt_st.wdata;
          IDX_FIXB: nxt_st.fixb = nxt_st.wdata;
          IDX_WIN: nxt_st.win = nxt_st.wdata;
          IDX_SDET: nxt_st.bresp = RESP_OKAY;
          default: nxt_st.bresp = RESP_SLVERR;
        endcase
      end else if (!(widx inside {IDX_INPWR, IDX_OSEL1, IDX_OSEL2, IDX_FIXA,
                   IDX_FIXB, IDX_WIN, IDX_SDET})) begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end

    // Reads answer one cycle after the address is taken.
    ridx = s_axi_araddr_i[7:2];
    rd = 8'h00;
    unique case (ridx)
      IDX_INPWR: rd = st_ff.inpwr;
      IDX_OSEL1: rd = st_ff.osel1;
      IDX_OSEL2: rd = st_ff.osel2;
      IDX_FIXA: rd = st_ff.fixa;
      IDX_FIXB: rd = st_ff.fixb;
      IDX_WIN: rd = st_ff.win;
      IDX_SDET: rd = 8'(st_ff.act) << ACT_B;
      default: rd = 8'h00;
    endcase
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      nxt_st.rresp = ((s_axi_araddr_i >> 8) == '0 && (ridx inside {IDX_INPWR,
        IDX_OSEL1, IDX_OSEL2, IDX_FIXA, IDX_FIXB, IDX_WIN, IDX_SDET})) ?
        RESP_OKAY : RESP_SLVERR;
    end

    // Power-down request from the pin, the register or the device.
    pin_req = (st_ff.pd_v == st_ff.inpwr[PD_POL_B]);
    if (st_ff.inpwr[PD_AUTO_B]) begin
      pd_req = !st_ff.act;
    end else begin
      pd_req = st_ff.inpwr[PD_REG_B] || pin_req;
    end
    nxt_st.powered = !pd_req || st_ff.inpwr[PD_FAST_B];

    // Output enables.
    nxt_st.pri_oe = st_ff.osel1[PRI_EN_B] && !st_ff.osel2[ALL_HIZ_B] && !pd_req;
    nxt_st.sec_oe = st_ff.osel1[SEC_EN_B] && !st_ff.osel2[ALL_HIZ_B] && !pd_req;
    nxt_st.vs_oe = !st_ff.osel2[ALL_HIZ_B] && !pd_req;
    nxt_st.dck_oe = !st_ff.osel2[ALL_HIZ_B] && !pd_req;
    nxt_st.sog_oe = !st_ff.osel2[SOG_HIZ_B] &&
                    !(pd_req && st_ff.inpwr[SOG_PD_HIZ_B]);

    // Drive strength: the upper bit wins.
    if (st_ff.osel1[DRV_HI_B]) begin
      nxt_st.drive = DRV_HIGH;
    end else if (st_ff.osel1[DRV_LO_B]) begin
      nxt_st.drive = DRV_MED;
    end else begin
      nxt_st.drive = DRV_LOW;
    end

    // Data clock: delayed, doubled and halved copies of the pixel clock.
    nxt_st.pck_dly = QUARTER_CYC'({st_ff.pck_dly, st_ff.pck_v});
    pix90 = st_ff.pck_dly[QUARTER_CYC-1];
    if (nxt_st.pck_v && !st_ff.pck_v) begin
      nxt_st.pck_half = !st_ff.pck_half;
    end
    unique case (clk_sel_t'(st_ff.osel2[CKSEL_HI:CKSEL_LO]))
      CK_PIX: ck = st_ff.pck_v;
      CK_PIX90: ck = pix90;
      CK_PIX2X: ck = st_ff.pck_v ^ pix90;
      CK_HALF: ck = st_ff.pck_half;
    endcase
    nxt_st.dck = ck ^ st_ff.osel1[CLK_INV_B];

    // Field encoding and sync routing.
    nxt_st.field = field_is_odd_i ^ st_ff.osel2[FIELD_POL_B];
    nxt_st.pll_ref = st_ff.osel2[PLL_FILT_B] ? sf.filtered : sf.raw;
    nxt_st.sproc = st_ff.osel2[SPROC_SEL_B] ? sf.regen : sf.raw;
  end

  // Register all state.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
      st_ff.inpwr <= RST_INPWR;
      st_ff.osel1 <= RST_OSEL1;
      st_ff.osel2 <= RST_OSEL2;
      st_ff.fixa <= RST_FIXA;
      st_ff.fixb <= RST_FIXB;
      st_ff.win <= RST_WIN;
      st_ff.mode <= MODE_RGB444;
      st_ff.pd_v <= 1'b1;
      // The power-down synchroniser starts at the pin's idle level, so no false request.
      st_ff.pd_s <= 3'b111;
      st_ff.powered <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus handshakes are combinational; payloads come from flip-flops.
  assign s_axi_awready_o = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready_o = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid_o = st_ff.bvalid;
  assign s_axi_bresp_o = st_ff.bresp;
  assign s_axi_arready_o = !st_ff.rvalid;
  assign s_axi_rvalid_o = st_ff.rvalid;
  assign s_axi_rdata_o = {24'h000000, st_ff.rdata};
  assign s_axi_rresp_o = st_ff.rresp;
  assign primary_oe_o = st_ff.pri_oe;
  assign secondary_oe_o = st_ff.sec_oe;
  assign vertical_sync_out_pin_oe_o = st_ff.vs_oe;
  assign green_sync_out_pin_o = st_ff.sog_v;
  assign green_sync_out_pin_oe_o = st_ff.sog_oe;
  assign data_clock_out_pin_o = st_ff.dck;
  assign data_clock_out_pin_oe_o = st_ff.dck_oe;
  assign drive_strength_o = st_ff.drive;
  assign output_mode_o = st_ff.mode;
  assign field_out_o = st_ff.field;
  assign pll_ref_sync_o = st_ff.pll_ref;
  assign sync_proc_sync_o = st_ff.sproc;
  assign core_powered_o = st_ff.powered;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Manual pin request in its active level cuts power unless fast.
  pd_pin_a: assert property (!st_ff.inpwr[PD_AUTO_B] && !st_ff.inpwr[PD_FAST_B] &&
    st_ff.pd_v == st_ff.inpwr[PD_POL_B] |=> !core_powered_o)
    else $error("pin power-down not honoured");
  // Power is only lost without fast switching.
  fast_switch_a: assert property (!core_powered_o |-> !$past(st_ff.inpwr[PD_FAST_B]))
    else $error("power lost while fast switching");
  // The format is always one of the defined codes.
  mode_valid_a: assert property (output_mode_o inside {MODE_RGB444, MODE_YCC422,
    MODE_DDR444})
    else $error("undefined output mode");
  // A reserved code leaves the format unchanged.
  mode_hold_a: assert property (s_axi_bvalid_o && !$past(s_axi_bvalid_o) &&
    st_ff.osel1 != $past(st_ff.osel1) && !(st_ff.osel1[MODE_HI:MODE_LO] inside
    {MODE_RGB444, MODE_YCC422, MODE_DDR444}) |-> $stable(output_mode_o))
    else $error("reserved mode changed the format");
  // The primary port drives only when enabled and not globally floated.
  pri_oe_a: assert property (primary_oe_o |-> $past(st_ff.osel1[PRI_EN_B] &&
    !st_ff.osel2[ALL_HIZ_B]))
    else $error("primary driven while disabled");
  // The secondary port floats on the cycle after its enable is low.
  sec_oe_a: assert property (!st_ff.osel1[SEC_EN_B] |=> !secondary_oe_o)
    else $error("secondary driven while disabled");
  // Global float held for two cycles leaves the clock and vsync undriven in the second.
  all_hiz_a: assert property (st_ff.osel2[ALL_HIZ_B] [*2] |->
    !data_clock_out_pin_oe_o && !vertical_sync_out_pin_oe_o)
    else $error("output driven in global float");
  // The green sync float bit always wins.
  sog_hiz_a: assert property (st_ff.osel2[SOG_HIZ_B] |=> !green_sync_out_pin_oe_o)
    else $error("green sync driven while floated");
  // An upper drive bit always means high strength.
  drive_a: assert property ($past(nrst_i) && $past(st_ff.osel1[DRV_HI_B]) |->
    drive_strength_o == DRV_HIGH)
    else $error("drive strength wrong");
  // A sync edge shows as activity on the next cycle.
  act_a: assert property (st_ff.hs0_v != $past(st_ff.hs0_v) |=> st_ff.act)
    else $error("sync activity missed");
  // A write answers in the cycle after both halves are taken.
  wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |=> s_axi_bvalid_o)
    else $error("write answer late");
endmodule : video_capture_output_control

/* tb/display_sink_model.sv */
// Downstream display processor model: counts data clock rises.
// Assumes the data clock pin and its enable come from the bank.
`timescale 1ns/10ps
module display_sink_model (
  // Data clock pin and its enable.
  input wire logic clk_i,
  input wire logic oe_i,
  // Count clear and result.
  input wire logic clr_i,
  output int edges_o
);
  // Only a driven clock is seen; a floating pin gives no edges.
  always @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      edges_o <= 0;
    end else if (oe_i) begin
      edges_o <= edges_o + 1;
    end
  end
endmodule : display_sink_model

/* tb/tb.sv */
// Testbench for the video output control bank.
// Assumes the design package and sink model are compiled first.
`timescale 1ns/10ps
module tb;
  import vcap_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, q;
  logic [1:0] r;
  logic pd = 1, hs0 = 0, hsx = 0, gsx = 0, pix = 0, ug = 0, odd = 0, clr = 1;
  wire awr, wr_, bv, arr, rv, po, so, vo, g, go, dc, dco, fo, pl, sp, cp;
  wire [1:0] bresp, rresp, drv;
  wire [2:0] md;
  wire [31:0] rd;
  int bad_count = 0, tests_run = 0, edges;
  logic [2:0] mds [4] = '{3'b100, 3'b101, 3'b110, 3'b111};
  logic [7:0] rvs [6] = '{RST_INPWR, RST_OSEL1, RST_OSEL2, RST_FIXA, RST_FIXB, RST_WIN};
  int ne [4] = '{10, 10, 20, 5};
  logic [1:0] cs [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
  video_capture_output_control #(.ACT_TIMEOUT_CYC(50)) DUT (.clk_sys_i, .nrst_i,
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rresp), .power_down_pin_i(pd), .horizontal_sync_input_zero_i(hs0),
    .selected_horizontal_sync_input_i(hsx), .selected_green_sync_input_i(gsx),
    .pixel_clock_i(pix), .use_green_sync_i(ug), .field_is_odd_i(odd), .primary_oe_o(po),
    .secondary_oe_o(so), .vertical_sync_out_pin_oe_o(vo), .green_sync_out_pin_o(g),
    .green_sync_out_pin_oe_o(go), .data_clock_out_pin_o(dc), .data_clock_out_pin_oe_o(dco),
    .drive_strength_o(drv), .output_mode_o(md), .field_out_o(fo), .pll_ref_sync_o(pl),
    .sync_proc_sync_o(sp), .core_powered_o(cp));
  display_sink_model SINK (.clk_i(dc), .oe_i(dco), .clr_i(clr), .edges_o(edges));
  // System clock and an unrelated 80 ns pixel clock.
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #3;
    forever #40 pix = ~pix;
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo();
    chk(0, 1);
    tally_and_finish();
  endtask : tmo
  // One bus transfer; readies and answers are looked at between edges.
  task automatic xf(input bit w, input logic [5:0] a, input logic [7:0] d);
    int n;
    logic pa, pw, ta, tw;
    pa = 1;
    pw = w;
    n = 0;
    if (w) begin
      awa <= {a, 2'b00};
      awv <= 1;
      wv <= 1;
      wd <= {24'h0, d};
      bry <= 1;
    end else begin
      ara <= {a, 2'b00};
      arv <= 1;
      rry <= 1;
    end
    while (pa || pw) begin
      @(negedge clk_sys_i);
      ta = pa && (w ? awr : arr) === 1;
      tw = pw && wr_ === 1;
      @(posedge clk_sys_i);
      if (ta) begin
        awv <= 0;
        arv <= 0;
      end
      if (tw) wv <= 0;
      pa = pa && !ta;
      pw = pw && !tw;
      if (++n > 50) tmo();
    end
    @(negedge clk_sys_i);
    while ((w ? bv : rv) !== 1) begin
      @(negedge clk_sys_i);
      if (++n > 99) tmo();
    end
    q = rd;
    r = w ? bresp : rresp;
    @(posedge clk_sys_i);
    bry <= 0;
    rry <= 0;
    @(posedge clk_sys_i);
  endtask : xf
  task automatic wrg(input logic [5:0] a, input logic [7:0] d);
    xf(1, a, d);
    chk(r, RESP_OKAY);
  endtask : wrg
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    xf(0, a, 0);
    chk(q, {24'h0, e});
  endtask : rdchk
  task automatic st(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : st
  // Main sequence of register calls and pin checks.
  initial begin
    st(4);
    nrst_i <= 1;
    st(10);
    chk(cp, 0);
    for (int i = 0; i < 6; i++) rdchk(6'(IDX_INPWR + i), rvs[i]);
    xf(0, 6'h3f, 0);
    chk(r, RESP_SLVERR);
    wrg(IDX_OSEL2, 8'h05);
    wrg(IDX_INPWR, 8'h20);
    st(3);
    chk(cp, 1);
    for (int i = 0; i < 4; i++) begin
      wrg(IDX_OSEL1, {mds[i], 2'b10, 2'(i), 1'b0});
      st(3);
      chk(md, mds[i < 3 ? i : 2]);
      chk(drv, i > 1 ? 2'b10 : 2'(i));
      chk({po, so}, 2'b10);
    end
    wrg(IDX_OSEL1, 8'h88);
    st(3);
    chk({po, so}, 2'b01);
    for (int i = 0; i < 4; i++) begin
      wrg(IDX_OSEL2, {cs[i], 6'h05});
      st(4);
      clr <= 0;
      st(80);
      chk(edges >= ne[i] - 1 && edges <= ne[i] + 1, 1);
      clr <= 1;
    end
    // The invert bit sets the data clock level a fixed time after a pixel clock rise.
    wrg(IDX_OSEL2, 8'h05);
    for (int k = 0; k < 2; k++) begin
      wrg(IDX_OSEL1, {7'h44, k[0]});
      @(posedge pix);
      st(6);
      chk(dc, !k[0]);
    end
    wrg(IDX_OSEL2, 8'h25);
    st(3);
    chk({so, dco, go, vo}, 4'b0010);
    wrg(IDX_OSEL2, 8'h15);
    st(3);
    chk({so, go, vo}, 3'b101);
    for (int j = 0; j < 4; j++) begin
      odd <= j[0];
      wrg(IDX_OSEL2, {4'h0, j[1], 3'b101});
      st(3);
      chk(fo, j[0] ^ j[1]);
    end
    wrg(IDX_INPWR, 8'h27);
    st(8);
    chk({cp, so, go}, 3'b100);
    wrg(IDX_INPWR, 8'h22);
    st(8);
    chk(so, 1);
    pd <= 0;
    st(8);
    chk({cp, so, go}, 3'b101);
    wrg(IDX_INPWR, 8'h20);
    st(8);
    chk(cp, 0);
    pd <= 1;
    // Raw routing follows the sync level; filtered paths only pulse.
    hsx <= 1;
    gsx <= 1;
    wrg(IDX_OSEL2, 8'h01);
    st(8);
    chk({pl, sp, g}, 3'b111);
    wrg(IDX_OSEL2, 8'h07);
    st(3);
    chk({pl, sp}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      hs0 <= ~hs0;
      st(6);
    end
    rdchk(IDX_SDET, 8'h80);
    st(80);
    rdchk(IDX_SDET, 8'h00);
    rdchk(IDX_FIXB, RST_FIXB);
    tally_and_finish();
  end
endmodule : tb
